// *** rtl/cwg_pkg.sv ***
// Package for the phase-delayed continuous-wave generator.
// Assumes one 250 MHz clock shared by bus and wave logic.
package cwg_pkg;
  localparam int CWG_CHANNELS = 8;
  localparam int CWG_LATENCY = 2;
  localparam logic [1:0] CWG_LAT_LAST = 2'h1;
  // Register byte addresses
  localparam logic [7:0] CWG_ADDR_DELAY0 = 8'h00;
  localparam logic [7:0] CWG_ADDR_MASK = 8'h20;
  localparam logic [7:0] CWG_ADDR_DIVISOR = 8'h24;
  localparam logic [7:0] CWG_ADDR_CTRL = 8'h28;
  localparam logic [7:0] CWG_ADDR_STATUS = 8'h2c;
  localparam int CWG_CTRL_RUN_BIT = 0;
  localparam int CWG_CTRL_EN_BIT = 1;
  localparam logic [7:0] CWG_RESET_BYTE = 8'h00;
  localparam logic [1:0] CWG_CTRL_RESET = 2'h2;
  localparam logic [8:0] CWG_MAX_HALF = 9'h100;
  localparam logic [1:0] CWG_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CWG_HSIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    CWG_IDLE = 4'h1,
    CWG_COUNT = 4'h2,
    CWG_HIGH = 4'h4,
    CWG_LOW = 4'h8
  } cwg_chan_state_t;

  // Drive for one channel pin: level and active-low output enable
  typedef struct packed {
    logic level;
    logic oe_n;
  } cwg_pin_t;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] divisor;
    logic run;
    logic enable;
  } cwg_cfg_t;
endpackage

// *** rtl/cwg_wave_gen.sv ***
// Eight-channel phase-delayed square wave generator with AHB-Lite registers.
// Assumes hclk is the transmit clock; pins resolved outside from oe_n.
// Operation
// RL1: Configure divisor, delays, mask first; sequence starts only on run rising.
// RL2: Delay countdown starts two clocks after run rises.
// RL3: Counter decrements to zero; next edge drives positive rail.
// RL4: Positive rail held divisor cycles, then negative rail.
// RL5: Negative rail held divisor cycles, then positive again, repeating.
// RL6: Run low stops every channel and floats its output.
// RL7: Each channel counts independently from one shared run start.
// RL8: Controller sets mask bit one for channels that must not drive.
// RL9: Controller holds enable high, other controls low before configuring.
// RL10: Controller raises run only when the whole system is ready.
// RL11: Outputs float while idle, during latency and countdown, or masked.
// RL12: Divisor zero means half period 256, period 512.
// RL13: Mask bit one disables channel and floats it; zero enables.
// RL14: Reset or enable low clears divisor, delays and mask.
// RL15: Eight-bit delay; output starts delay plus three clocks after run.
`timescale 1ns/1ns
module cwg_chan
  import cwg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic run,
  input wire logic masked,
  input wire logic [7:0] delay,
  input wire logic [8:0] half,
  output cwg_pin_t pin
);
  cwg_chan_state_t state, next_state;
  logic [8:0] cnt, next_cnt;
  cwg_pin_t next_pin;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      CWG_IDLE:
      begin
        if (go && !masked) // RL13
        begin
          next_state = CWG_COUNT;
          next_cnt = {1'b0, delay}; // RL7
        end
      end
      CWG_COUNT:
      begin
        if (cnt == 9'h000) // RL3
        begin
          next_state = CWG_HIGH;
          next_cnt = half - 9'h001;
        end
        else
        begin
          next_cnt = cnt - 9'h001; // RL3
        end
      end
      CWG_HIGH:
      begin
        if (cnt == 9'h000) // RL4
        begin
          next_state = CWG_LOW;
          next_cnt = half - 9'h001;
        end
        else
        begin
          next_cnt = cnt - 9'h001;
        end
      end
      CWG_LOW:
      begin
        if (cnt == 9'h000) // RL5
        begin
          next_state = CWG_HIGH;
          next_cnt = half - 9'h001;
        end
        else
        begin
          next_cnt = cnt - 9'h001;
        end
      end
      default:
      begin
        next_state = CWG_IDLE;
      end
    endcase
    if (!run || masked) // RL6
    begin
      next_state = CWG_IDLE;
    end
    // Drive only in the wave states; float otherwise
    next_pin.level = (next_state == CWG_HIGH);
    next_pin.oe_n = !((next_state == CWG_HIGH) || (next_state == CWG_LOW)); // RL11
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= CWG_IDLE;
      cnt <= 9'h000;
      pin <= '{level: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      pin <= next_pin;
    end
  end
endmodule

module cwg_wave_gen
  import cwg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output cwg_pin_t [7:0] wave_out
);
  logic [7:0] channel_start_delay [CWG_CHANNELS];
  logic [7:0] next_delay [CWG_CHANNELS];
  cwg_cfg_t cfg, next_cfg;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic run_q, next_run_q;
  logic [1:0] lat, next_lat;
  logic go;
  logic [8:0] half;
  logic addr_ok;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && (htrans == CWG_HTRANS_NONSEQ) && (hsize == CWG_HSIZE_WORD);
  // Zero divisor selects the longest half period
  assign half = (cfg.divisor == CWG_RESET_BYTE) ? CWG_MAX_HALF : {1'b0, cfg.divisor}; // RL12

  always_comb
  begin
    next_cfg = cfg;
    next_delay = channel_start_delay;
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_hrdata = 32'h0000_0000;
    if (wr_pend)
    begin
      if (wr_addr < CWG_ADDR_MASK && wr_addr[1:0] == 2'h0)
      begin
        next_delay[wr_addr[4:2]] = hwdata[7:0]; // RL15
      end
      unique case (wr_addr)
        CWG_ADDR_MASK: next_cfg.mask = hwdata[7:0];
        CWG_ADDR_DIVISOR: next_cfg.divisor = hwdata[7:0];
        CWG_ADDR_CTRL:
        begin
          next_cfg.run = hwdata[CWG_CTRL_RUN_BIT];
          next_cfg.enable = hwdata[CWG_CTRL_EN_BIT];
        end
        default: next_cfg.run = next_cfg.run;
      endcase
    end
    if (!next_cfg.enable) // RL14
    begin
      next_cfg.mask = CWG_RESET_BYTE;
      next_cfg.divisor = CWG_RESET_BYTE;
      next_cfg.run = 1'b0;
      for (int i = 0; i < CWG_CHANNELS; i++)
      begin
        next_delay[i] = CWG_RESET_BYTE;
      end
    end
    if (addr_ok && !hwrite)
    begin
      if (haddr[7:0] < CWG_ADDR_MASK && haddr[1:0] == 2'h0)
      begin
        next_hrdata = {24'h000000, channel_start_delay[haddr[4:2]]};
      end
      else
      begin
        unique case (haddr[7:0])
          CWG_ADDR_MASK: next_hrdata = {24'h000000, cfg.mask};
          CWG_ADDR_DIVISOR: next_hrdata = {24'h000000, cfg.divisor};
          CWG_ADDR_CTRL: next_hrdata = {30'h0, cfg.enable, cfg.run};
          CWG_ADDR_STATUS:
          begin
            for (int i = 0; i < CWG_CHANNELS; i++)
            begin
              next_hrdata[i] = !wave_out[i].oe_n;
            end
          end
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
    // Latency counter armed on run rising edge only
    next_run_q = cfg.run;
    next_lat = lat;
    if (cfg.run && !run_q) // RL1
    begin
      next_lat = CWG_LAT_LAST;
    end
    else if (lat != 2'h0)
    begin
      next_lat = lat - 2'h1; // RL2
    end
    if (!cfg.run)
    begin
      next_lat = 2'h0;
    end
  end

  // Pulse one clock after run rises
  assign go = cfg.run && (lat == 2'h1); // RL2

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg <= '{mask: 8'h00, divisor: 8'h00, run: 1'b0, enable: 1'b1};
      for (int i = 0; i < CWG_CHANNELS; i++)
      begin
        channel_start_delay[i] <= 8'h00; // RL14
      end
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      run_q <= 1'b0;
      lat <= 2'h0;
    end
    else
    begin
      cfg <= next_cfg;
      channel_start_delay <= next_delay;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      run_q <= next_run_q;
      lat <= next_lat;
    end
  end

  for (genvar g = 0; g < CWG_CHANNELS; g++)
  begin : g_chan
    cwg_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .go(go),
      .run(cfg.run), // RL6
      .masked(cfg.mask[g]), // RL13
      .delay(channel_start_delay[g]),
      .half(half),
      .pin(wave_out[g])
    );
  end
endmodule

// *** verification/cwg_wave_gen_properties.sv ***
// Port checks for the wave generator.
// Assumes enable is set whenever run is written.
`timescale 1ns/1ns
module cwg_props
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cwg_pkg::cwg_pin_t [7:0] wave_out
);
  import cwg_pkg::*;
  logic [7:0] wa, oe, mask;
  logic wv, rv, run;
  logic [8:0] half, cnt;
  always_comb
    for (int i = 0; i < 8; i++)
      oe[i] = wave_out[i].oe_n;
  // Shadow of bus writes, so no internal signal is needed
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      run <= 1'b0;
      mask <= 8'h00;
      half <= CWG_MAX_HALF;
    end
    else
    begin
      if (wv && wa == CWG_ADDR_CTRL) run <= &hwdata[1:0];
      if (wv && wa == CWG_ADDR_MASK) mask <= hwdata[7:0];
      if (wv && wa == CWG_ADDR_DIVISOR)
        half <= hwdata[7:0] == 8'h00 ? CWG_MAX_HALF : {1'b0, hwdata[7:0]};
    end
  always_ff @(posedge hclk)
  begin
    wv <= hsel && htrans == CWG_HTRANS_NONSEQ && hwrite;
    rv <= hsel && htrans == CWG_HTRANS_NONSEQ && !hwrite;
    wa <= haddr[7:0];
    cnt <= $changed(wave_out[0]) ? 9'h001 : cnt + 9'h001;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  idle_float_a: assert property (!run |=> &oe) else $error("drive while stopped");
  start_latency_a: assert property ($rose(run) |-> (&oe) [*3])
    else $error("early start");
  start_positive_a: assert property ($fell(oe[0]) |-> wave_out[0].level)
    else $error("first level negative");
  half_period_a: assert property (!$past(oe[0]) && !oe[0] && $changed(wave_out[0].level)
    |-> cnt == half) else $error("half period wrong");
  mask_float_a: assert property ((~oe & $past(mask)) == 8'h00)
    else $error("masked channel driven");
  start_bound_a: assert property ($rose(run) && !mask[0] |-> ##[3:258] !oe[0])
    else $error("no start");
  read_upper_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
  read_idle_a: assert property (!rv |-> hrdata == 32'h0) else $error("read data held");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("wait state or error response");
endmodule
bind cwg_wave_gen cwg_props chk_u (.*);

// *** verification/cwg_host.sv ***
// Controller model: AHB-Lite master for the generator registers.
// Assumes one slave whose hreadyout returns as hready.
`timescale 1ns/1ns
module cwg_host
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h0,
  output logic [31:0] hwdata = 32'h0
);
  import cwg_pkg::*;
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= CWG_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= CWG_HSIZE_WORD;
    do @(posedge hclk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (!hready);
    q = hrdata;
    // Invert hwdata after the data phase; after a read it returns to its earlier value
    hwdata <= ~hwdata;
  endtask
endmodule

// *** verification/tb_top.sv ***
// Bench: register access, start timing, masking, divisor zero, stop.
// Assumes the host model is the only bus master.
`timescale 1ns/1ns
module tb_top;
  import cwg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cwg_pin_t [7:0] wave_out;
  int fails = 0, check_count = 0, cyc = 0, e;
  int start [8];
  always #2 hclk = ~hclk;
  cwg_host host_u (.hready(hreadyout), .*);
  cwg_wave_gen dut_u (.hready(hreadyout), .*);
  function automatic logic [31:0] dly(int i);
    return i == 6 ? 32'h000000ff : 32'(i * 3);
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) fails++;
    if (got !== exp) $display("ERROR at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic conclude;
    if (cyc >= 3000) fails++;
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000) conclude();
  end
  // First driving cycle of each channel
  always @(negedge hclk)
    for (int i = 0; i < 8; i++)
      if (start[i] == 0 && wave_out[i].oe_n === 1'b0) start[i] = cyc;
  initial
  begin
    start = '{default: 0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 'h34; a += 4)
      rd(8'(a), a == 'h28 ? 32'h2 : 32'h0);
    for (int i = 0; i < 8; i++)
      host_u.xfer(1'b1, 8'(i * 4), dly(i), q);
    host_u.xfer(1'b1, CWG_ADDR_MASK, 32'h80, q);
    host_u.xfer(1'b1, CWG_ADDR_DIVISOR, 32'h4, q);
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), dly(i));
    host_u.xfer(1'b1, CWG_ADDR_CTRL, 32'h3, q);
    @(negedge hclk);
    e = cyc;
    repeat (300) @(posedge hclk);
    for (int i = 0; i < 7; i++)
      check(start[i] - e, dly(i) + 3);
    check(start[7], 0);
    host_u.xfer(1'b1, CWG_ADDR_MASK, 32'h82, q);
    @(posedge hclk);
    rd(CWG_ADDR_STATUS, 32'h7d);
    host_u.xfer(1'b1, CWG_ADDR_CTRL, 32'h2, q);
    @(posedge hclk);
    rd(CWG_ADDR_STATUS, 32'h0);
    host_u.xfer(1'b1, CWG_ADDR_DIVISOR, 32'h0, q);
    host_u.xfer(1'b1, CWG_ADDR_CTRL, 32'h3, q);
    repeat (600) @(posedge hclk);
    host_u.xfer(1'b1, CWG_ADDR_CTRL, 32'h0, q);
    rd(CWG_ADDR_DELAY0 + 8'h04, 32'h0);
    conclude();
  end
endmodule
